// ==== hdl/scan_port_defines.svh ====
`ifndef SCAN_PORT_DEFINES_SVH
`define SCAN_PORT_DEFINES_SVH

// Chain and macro sizes
`define JK_CELLS       20
`define JK_BANK_CELLS  10
`define OUT_CELLS      16
`define IN_CELLS       16
`define BANK_CELLS     8
`define CLK_TERMS      10
`define DATA_SYNC_W    99

// Register byte offsets
`define REG_CTRL       8'h00
`define REG_IN_BYPASS  8'h04
`define REG_OUT_BYPASS 8'h08
`define REG_JK_STATE   8'h0c
`define REG_OUT_STATE  8'h10
`define REG_IN_STATE   8'h14
`define REG_STATUS     8'h18

// Field positions
`define CTRL_SECURE_BIT  0
`define STAT_SCAN_BIT    0
`define STAT_PDOWN_BIT   1
`define STAT_OFF_BIT     2

// Reset values
`define CTRL_RESET     1'b0
`define BYPASS_RESET   16'h0000

// AXI response codes
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10

`endif

// ==== hdl/scan_port_pkg.sv ====
package scan_port_pkg;
  // Operating mode, Gray coded along normal, scan, power-down
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_SCAN   = 2'b01,
    MODE_PDOWN  = 2'b11
  } mode_t;
endpackage : scan_port_pkg

// ==== hdl/sync2.sv ====
// Two-flop synchroniser for a bundle of asynchronous levels
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;  // First stage, read only by second stage

  // Both stages clear on reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : sync2

// ==== hdl/scan_chain_test_port.sv ====
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`include "scan_port_defines.svh"
// Notes on behaviour
// - Mode pin high enters scan mode.
// - Chain is 20 buried then 16 output.
// - Scan input feeds the chain head.
// - Scan clock alone clocks chain in scan.
// - Preset and clear disabled during scan.
// - Bypassed output flops still shift in scan.
// - External data inputs blocked in scan.
// - Pins show inverted output flops in scan.
// - Security fuse never disables scan.
// - Head bit reaches pin 0 at 21, 15 at 36.
// - Chain behaves as first-in first-out shifter.
// - Power-down pin high freezes all 52 flops.
// - Scan input high in power-down disables outputs.
// - Power-on clears all 52 flops.
// - Input flops in two banks, individual bypass.
// - Clock array: ten single, one common term.
module scan_chain_test_port
  import scan_port_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Scan and power pins
  input  wire logic        scan_mode_select,
  input  wire logic        scan_serial_in,
  input  wire logic        scan_shift_clock,
  input  wire logic        power_down_pin,
  // Normal clocks: input banks, output banks, clock array terms
  input  wire logic        clk_in_a,
  input  wire logic        clk_in_b,
  input  wire logic        clk_out_a,
  input  wire logic        clk_out_b,
  input  wire logic [9:0]  jk_clk_term,
  input  wire logic        jk_clk_common,
  // Array-side data into the flops
  input  wire logic [15:0] in_pin,
  input  wire logic [19:0] jk_j,
  input  wire logic [19:0] jk_k,
  input  wire logic [15:0] out_data,
  input  wire logic [15:0] out_enable_term,
  input  wire logic        flop_preset,
  input  wire logic [9:0]  flop_clear,
  // I/O pin drive
  output logic      [15:0] io_out,
  output logic      [15:0] io_oe,
  output logic             output_disable_term,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // Synchronised pins
  logic [3:0]  pins_s;       // pd, sck, sci, scm
  logic [14:0] clks_s;       // Normal clocks
  logic [98:0] data_s;       // Array-side data
  logic        pd_s;
  logic        sci_s;
  logic        scm_s;
  logic [15:0] clk_vec_s;    // All clocks incl. scan clock
  logic [15:0] clk_prev_q;   // Previous sampled clocks
  logic [15:0] clk_rise;     // One-cycle rising edge pulses
  logic [15:0] in_s;
  logic [19:0] j_s;
  logic [19:0] k_s;
  logic [15:0] outd_s;
  logic [15:0] oe_s;
  logic        pre_s;
  logic [9:0]  clr_s;
  // Flop state
  logic [19:0] jk_q, jk_d;   // Buried JK cells
  logic [15:0] out_q, out_d; // Output D cells
  logic [15:0] in_q, in_d;   // Input D cells
  logic [15:0] io_d;
  logic [15:0] oe_d;
  mode_t       mode_q, mode_d;
  // Software registers
  logic        secure_q, secure_d;
  logic [15:0] in_byp_q, in_byp_d;
  logic [15:0] out_byp_q, out_byp_d;
  // AXI state
  logic        aw_have_q, aw_have_d;
  logic        w_have_q, w_have_d;
  logic [7:0]  aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0]  s_wstrb_q;    // Strobes held with write data
  logic        bvalid_d;
  logic [1:0]  bresp_d;
  logic        rvalid_d;
  logic [31:0] rdata_d;
  logic [1:0]  rresp_d;

  // Pin synchronisers
  sync2 #(.W(4)) u_sync_pins (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({power_down_pin, scan_shift_clock, scan_serial_in,
                scan_mode_select}),
    .sync_out (pins_s)
  );
  sync2 #(.W(15)) u_sync_clks (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({jk_clk_common, jk_clk_term, clk_out_b, clk_out_a,
                clk_in_b, clk_in_a}),
    .sync_out (clks_s)
  );
  sync2 #(.W(`DATA_SYNC_W)) u_sync_data (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({clr_in_cat(flop_clear, flop_preset), out_enable_term,
                out_data, jk_k, jk_j, in_pin}),
    .sync_out (data_s)
  );

  // Joins clear and preset into one field
  function automatic logic [10:0] clr_in_cat(input logic [9:0] c,
                                             input logic p);
    clr_in_cat = {c, p};
  endfunction : clr_in_cat

  // Unpack synchronised bundles
  assign pd_s      = pins_s[3];
  assign sci_s     = pins_s[1];
  assign scm_s     = pins_s[0];
  assign clk_vec_s = {clks_s, pins_s[2]};
  assign clk_rise  = clk_vec_s & ~clk_prev_q;
  assign in_s      = data_s[15:0];
  assign j_s       = data_s[35:16];
  assign k_s       = data_s[55:36];
  assign outd_s    = data_s[71:56];
  assign oe_s      = data_s[87:72];
  assign pre_s     = data_s[88];
  assign clr_s     = data_s[98:89];

  // Next flop state for all three macro groups
  always_comb begin
    jk_d  = jk_q;
    out_d = out_q;
    in_d  = in_q;
    if (pd_s) begin
      mode_d = MODE_PDOWN;
    end else if (scm_s) begin
      mode_d = MODE_SCAN;
    end else begin
      mode_d = MODE_NORMAL;
    end
    if (mode_d == MODE_PDOWN) begin
      jk_d = jk_q;
    end else if (mode_d == MODE_SCAN) begin
      if (clk_rise[0]) begin
        jk_d  = {jk_q[18:0], sci_s};
        out_d = {out_q[14:0], jk_q[19]};
      end
    end else begin
      for (int i = 0; i < `IN_CELLS; i++) begin
        if (!in_byp_q[i] && clk_rise[(i < `BANK_CELLS) ? 1 : 2]) begin
          in_d[i] = in_s[i];
        end
        if (out_byp_q[i]) begin
          out_d[i] = outd_s[i];
        end else if (clk_rise[(i < `BANK_CELLS) ? 3 : 4]) begin
          out_d[i] = outd_s[i];
        end
      end
      // ten single terms, one common term
      for (int i = 0; i < `JK_CELLS; i++) begin
        if (i < `JK_BANK_CELLS) begin
          if (clr_s[i]) begin
            jk_d[i] = 1'b0;
          end else if (clk_rise[5 + i]) begin
            jk_d[i] = (j_s[i] & ~jk_q[i]) | (~k_s[i] & jk_q[i]);
          end
        end else begin
          if (pre_s) begin
            jk_d[i] = 1'b1;
          end else if (clk_rise[15]) begin
            jk_d[i] = (j_s[i] & ~jk_q[i]) | (~k_s[i] & jk_q[i]);
          end
        end
      end
    end
    // inverted output cells on pins in scan
    io_d = (mode_d == MODE_SCAN) ? ~out_d : out_d;
    // scan input disables outputs in power-down
    oe_d = (pd_s && sci_s) ? 16'h0000 : oe_s;
  end

  // Flop state registers, all clear at power-on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      jk_q       <= '0;
      out_q      <= '0;
      in_q       <= '0;
      io_out     <= '0;
      io_oe      <= '0;
      mode_q     <= MODE_NORMAL;
      clk_prev_q <= '0;
    end else begin
      jk_q       <= jk_d;
      out_q      <= out_d;
      in_q       <= in_d;
      io_out     <= io_d;
      io_oe      <= oe_d;
      mode_q     <= mode_d;
      clk_prev_q <= clk_vec_s;
    end
  end

  // Disable term set when the registered enables are all off in power-down
  assign output_disable_term = (mode_q == MODE_PDOWN) && (io_oe == '0);

  // Register writes and read answers
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    aw_addr_d = aw_addr_q;
    w_data_d  = w_data_q;
    bvalid_d  = s_axi_bvalid;
    bresp_d   = s_axi_bresp;
    rvalid_d  = s_axi_rvalid;
    rdata_d   = s_axi_rdata;
    rresp_d   = s_axi_rresp;
    secure_d  = secure_q;
    in_byp_d  = in_byp_q;
    out_byp_d = out_byp_q;
    // Capture address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_d = 1'b1;
      w_data_d = s_axi_wdata;
    end
    // Response done
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    // Perform write once both halves held
    if (aw_have_q && w_have_q) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = `RESP_OKAY;
      case (aw_addr_q)
        `REG_CTRL: begin
          if (s_wstrb_q[0]) begin
            secure_d = w_data_q[`CTRL_SECURE_BIT];
          end
        end
        `REG_IN_BYPASS: begin
          if (s_wstrb_q[0]) in_byp_d[7:0] = w_data_q[7:0];
          if (s_wstrb_q[1]) in_byp_d[15:8] = w_data_q[15:8];
        end
        `REG_OUT_BYPASS: begin
          if (s_wstrb_q[0]) out_byp_d[7:0] = w_data_q[7:0];
          if (s_wstrb_q[1]) out_byp_d[15:8] = w_data_q[15:8];
        end
        `REG_JK_STATE, `REG_OUT_STATE, `REG_IN_STATE, `REG_STATUS: begin
          bresp_d = `RESP_OKAY;
        end
        default: begin
          bresp_d = `RESP_SLVERR;
        end
      endcase
    end
    // Read answer done
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    // Read decode
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = `RESP_OKAY;
      rdata_d  = 32'h0000_0000;
      case (s_axi_araddr)
        `REG_CTRL:       rdata_d[0] = secure_q;
        `REG_IN_BYPASS:  rdata_d[15:0] = in_byp_q;
        `REG_OUT_BYPASS: rdata_d[15:0] = out_byp_q;
        `REG_JK_STATE:   rdata_d[19:0] = secure_q ? 20'h00000 : jk_q;
        `REG_OUT_STATE:  rdata_d[15:0] = secure_q ? 16'h0000 : out_q;
        `REG_IN_STATE:   rdata_d[15:0] = secure_q ? 16'h0000 : in_q;
        `REG_STATUS: begin
          rdata_d[`STAT_SCAN_BIT]  = (mode_q == MODE_SCAN);
          rdata_d[`STAT_PDOWN_BIT] = (mode_q == MODE_PDOWN);
          rdata_d[`STAT_OFF_BIT]   = output_disable_term;
        end
        default: begin
          rresp_d = `RESP_SLVERR;
        end
      endcase
    end
  end

  // Bus registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      aw_addr_q    <= 8'h00;
      w_data_q     <= 32'h0000_0000;
      s_wstrb_q    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
      secure_q     <= `CTRL_RESET;
      in_byp_q     <= `BYPASS_RESET;
      out_byp_q    <= `BYPASS_RESET;
    end else begin
      aw_have_q    <= aw_have_d;
      w_have_q     <= w_have_d;
      aw_addr_q    <= aw_addr_d;
      w_data_q     <= w_data_d;
      s_wstrb_q    <= (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb
                                                     : s_wstrb_q;
      s_axi_bvalid <= bvalid_d;
      s_axi_bresp  <= bresp_d;
      s_axi_rvalid <= rvalid_d;
      s_axi_rdata  <= rdata_d;
      s_axi_rresp  <= rresp_d;
      secure_q     <= secure_d;
      in_byp_q     <= in_byp_d;
      out_byp_q    <= out_byp_d;
    end
  end

  // Ready while the channel holder is empty and no answer is pending
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_head_capture: assert property (
    (mode_d == MODE_SCAN && clk_rise[0]) |=> jk_q[0] == $past(sci_s))
    else $error("chain head missed scan input");
  chk_chain_link: assert property (
    (mode_d == MODE_SCAN && clk_rise[0]) |=> out_q[0] == $past(jk_q[19]))
    else $error("buried to output link broken");
  chk_scan_hold: assert property (
    (mode_d == MODE_SCAN && !clk_rise[0]) |=> $stable(jk_q) && $stable(out_q))
    else $error("chain moved without scan clock");
  chk_scan_invert: assert property (
    (mode_q == MODE_SCAN) |-> io_out == ~out_q)
    else $error("scan pins not inverted");
  chk_pd_freeze: assert property (
    pd_s |=> $stable(jk_q) && $stable(out_q) && $stable(in_q))
    else $error("state changed in power-down");
  chk_pd_outoff: assert property (
    (pd_s && sci_s) |=> io_oe == 16'h0000)
    else $error("outputs on in power-down");
  chk_reset_clear: assert property (disable iff (1'b0)
    !aresetn |=> jk_q == '0 && out_q == '0 && in_q == '0)
    else $error("flops not cleared by reset");
  chk_secure_scan: assert property (
    (secure_q && mode_d == MODE_SCAN && clk_rise[0])
      |=> jk_q[0] == $past(sci_s))
    else $error("secure blocked scan shift");
  chk_in_bank_hold: assert property (
    (mode_d == MODE_NORMAL && !clk_rise[1] && !clk_rise[2])
      |=> $stable(in_q))
    else $error("input cells moved without bank clock");
endmodule : scan_chain_test_port

// ==== sim/scan_tester_model.sv ====
// Test equipment on the scan pins; it makes the scan clock itself
module scan_tester_model (
  output logic scan_shift_clock,
  output logic scan_serial_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scan_shift_clock = 1'b0;
    scan_serial_in   = 1'b0;
  end

  // one pulse per serial bit
  // Caller starts on a falling aclk edge; with its wait the period is 160 ns
  task automatic shift_bit(input logic b);
    scan_serial_in = b;
    #80 scan_shift_clock = 1'b1;
    #70 scan_shift_clock = 1'b0;
    // Hold time over, the line no longer shows the bit
    scan_serial_in = ~b;
  endtask : shift_bit

  // static level used as output control in power-down
  task automatic hold_in(input logic b);
    scan_serial_in = b;
  endtask : hold_in
endmodule : scan_tester_model

// ==== sim/scan_chain_test_port_tb.sv ====
`include "scan_port_defines.svh"
// Random scan streams with fixed fills, power-down and register access
module scan_chain_test_port_tb;
  import scan_port_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        aclk, aresetn, scan_mode_select, scan_serial_in;
  logic        scan_shift_clock, power_down_pin, clk_in_a, clk_in_b;
  logic        clk_out_a, clk_out_b, jk_clk_common, flop_preset;
  logic        output_disable_term, noise;
  logic [9:0]  jk_clk_term, flop_clear;
  logic [15:0] in_pin, out_data, out_enable_term, io_out, io_oe;
  logic [19:0] jk_j, jk_k;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [35:0] ref_q;      // Expected chain, bit 0 is the head cell
  int          failures, n_checks, cyc;

  scan_chain_test_port DUT (.aclk, .aresetn, .scan_mode_select,
    .scan_serial_in, .scan_shift_clock, .power_down_pin, .clk_in_a,
    .clk_in_b, .clk_out_a, .clk_out_b, .jk_clk_term, .jk_clk_common,
    .in_pin, .jk_j, .jk_k, .out_data, .out_enable_term, .flop_preset,
    .flop_clear, .io_out, .io_oe, .output_disable_term, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  scan_tester_model tester (.scan_shift_clock, .scan_serial_in);

  // Free-running system clock
  initial aclk = 1'b0;
  always #5 aclk = ~aclk;

  // Timeout and random traffic on normal clocks and data
  always @(posedge aclk) begin
    if (noise) begin
      {clk_in_a, clk_in_b, clk_out_a, clk_out_b} <= 4'($urandom);
      {jk_clk_common, flop_preset} <= 2'($urandom);
      jk_clk_term <= 10'($urandom);
      flop_clear <= 10'($urandom);
      in_pin <= 16'($urandom);
      out_data <= 16'($urandom);
      jk_j <= 20'($urandom);
      jk_k <= 20'($urandom);
    end else begin
      // Levels that would alter cells outside scan
      flop_preset <= 1'b0;
      flop_clear <= 10'h000;
    end
    cyc++;
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
  end

  task automatic chk(input string n, input logic [35:0] s, e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Pin effects take three cycles through the synchronisers
  task automatic settle;
    repeat (4) @(posedge aclk);
  endtask : settle

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er = `RESP_OKAY);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_wstrb <= 4'hf;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    chk("bresp", 36'(s_axi_bresp), 36'(er));
    s_axi_bready <= 1'b0;
  endtask : axw

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                       input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    chk("rresp", 36'(s_axi_rresp), 36'(er));
    if (er === `RESP_OKAY) chk("rdata", 36'(s_axi_rdata), 36'(e));
    s_axi_rready <= 1'b0;
  endtask : rdchk

  // One scan clock; pins show the inverted output cells
  task automatic sh(input logic b);
    @(negedge aclk);
    tester.shift_bit(b);
    ref_q = {ref_q[34:0], b};
    chk("io_out", 36'(io_out), {20'h0, ~ref_q[35:20]});
  endtask : sh

  task automatic final_report;
    if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report

  // Main sequence
  initial begin
    cyc = $urandom(56);
    {cyc, failures, n_checks, noise, aresetn} = '0;
    {scan_mode_select, power_down_pin, clk_in_a, clk_in_b} = '0;
    {clk_out_a, clk_out_b, jk_clk_common, flop_preset} = '0;
    {jk_clk_term, flop_clear, in_pin, out_data, jk_j, jk_k} = '0;
    // output enables kept on for observation
    out_enable_term = 16'hffff;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    ref_q = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    settle();
    chk("io_out", 36'(io_out), 36'h0);
    for (int a = 0; a <= 24; a += 4) rdchk(8'(a), 32'h0, `RESP_OKAY);
    rdchk(8'h1c, 32'h0, `RESP_SLVERR);
    axw(8'h1c, 32'h0, `RESP_SLVERR);
    scan_mode_select <= 1'b1;
    settle();
    rdchk(`REG_STATUS, 32'h1, `RESP_OKAY);
    // bypass and security set while shifting
    axw(`REG_OUT_BYPASS, 32'hffff);
    axw(`REG_CTRL, 32'h1);
    axw(`REG_IN_BYPASS, $urandom);
    // normal clocks and data toggle meanwhile
    noise <= 1'b1;
    repeat (36) sh(1'b1);
    repeat (36) sh(1'b0);
    repeat (72) sh(1'($urandom));
    noise <= 1'b0;
    axw(`REG_OUT_BYPASS, 32'h0);
    axw(`REG_CTRL, 32'h0);
    rdchk(`REG_OUT_STATE, {16'h0, ref_q[35:20]}, `RESP_OKAY);
    scan_mode_select <= 1'b0;
    settle();
    chk("io_out", 36'(io_out), 36'(ref_q[35:20]));
    // one system clock on output bank A
    {clk_out_a, clk_out_b} <= 2'b00;
    out_data <= 16'($urandom);
    settle();
    clk_out_a <= 1'b1;
    settle();
    ref_q[27:20] = out_data[7:0];
    chk("io_out", 36'(io_out), 36'(ref_q[35:20]));
    power_down_pin <= 1'b1;
    settle();
    @(negedge aclk);
    tester.hold_in(1'b1);
    out_data <= ~out_data;
    settle();
    chk("io_oe", 36'(io_oe), 36'h0);
    chk("disable", 36'(output_disable_term), 36'h1);
    chk("io_out", 36'(io_out), 36'(ref_q[35:20]));
    rdchk(`REG_STATUS, 32'h6, `RESP_OKAY);
    @(negedge aclk);
    tester.hold_in(1'b0);
    settle();
    chk("io_oe", 36'(io_oe), 36'(out_enable_term));
    chk("disable", 36'(output_disable_term), 36'h0);
    power_down_pin <= 1'b0;
    settle();
    scan_mode_select <= 1'b1;
    settle();
    chk("io_out", 36'(io_out), {20'h0, ~ref_q[35:20]});
    repeat (8) sh(1'($urandom));
    final_report();
  end
endmodule : scan_chain_test_port_tb
